//--- shared/psb_pkg.sv
package psb_pkg;

  // ==========================================================
  // bus geometry
  localparam int AW        = 21;
  localparam int DW        = 16;
  localparam int MEM_AW    = 8;
  localparam int MEM_DEPTH = 256;
  localparam int ROW_AW    = 7;
  localparam int ROW_WORDS = 128;
  localparam int FIFO_DEPTH = 8;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS        = 100;
  localparam int MAX_SELECT_LOW_NS    = 4000;
  localparam int MAX_SELECT_LOW_CYC   = MAX_SELECT_LOW_NS / CLK_PERIOD_NS;
  localparam int SELECT_LOW_MARGIN    = 4;
  localparam logic [5:0] SELECT_LOW_LIMIT = 6'(MAX_SELECT_LOW_CYC - SELECT_LOW_MARGIN);
  localparam int REFRESH_HIGH_NS      = 15;
  localparam int REFRESH_HIGH_CYC     = REFRESH_HIGH_NS / CLK_PERIOD_NS + 1;
  localparam int SELECT_HIGH_GAP_NS   = 5;
  localparam int SELECT_HIGH_GAP_CYC  = (SELECT_HIGH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] GAP_CYC      = 4'((REFRESH_HIGH_CYC > SELECT_HIGH_GAP_CYC) ?
                                           REFRESH_HIGH_CYC : SELECT_HIGH_GAP_CYC);
  localparam int ASYNC_ACCESS_NS      = 70;
  localparam logic [3:0] ASYNC_CYC    = 4'((ASYNC_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1);

  // ==========================================================
  // controller register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CFG    = 8'h04;
  localparam logic [7:0] REG_ADDR   = 8'h08;
  localparam logic [7:0] REG_COUNT  = 8'h0C;
  localparam logic [7:0] REG_WDATA  = 8'h10;
  localparam logic [7:0] REG_RDATA  = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam int CTRL_GO       = 0;
  localparam int CTRL_WRITE    = 1;
  localparam int CTRL_ASYNC    = 2;
  localparam int STAT_BUSY     = 0;
  localparam int STAT_RD_VALID = 1;
  localparam int STAT_FULL     = 2;
  localparam int STAT_EMPTY    = 3;
  localparam int STAT_WAIT_ERR = 4;
  localparam logic [2:0] LATENCY_CODE_RST = 3'h2;

  // ==========================================================
  // states
  typedef enum {DS_IDLE, DS_LAT, DS_DATA, DS_ROWEND} psb_dev_state_t;
  typedef enum {HS_IDLE, HS_START, HS_RUN, HS_ASETUP, HS_ASYNC, HS_AEND, HS_GAP} psb_host_state_t;

endpackage

//--- shared/psb_bus_if.sv
`timescale 1ns/1ns
`default_nettype none
interface psb_bus_if
  import psb_pkg::*;
();
  logic          bus_clk;
  logic          sel_n;
  logic          address_valid_n;
  logic          oe_n;
  logic          we_n;
  logic [AW-1:0] addr;
  logic [DW-1:0] h_dq_o;
  logic          h_dq_oe;
  logic [DW-1:0] d_dq_o;
  logic          d_dq_oe;
  logic          wait_n;
  logic [DW-1:0] dq;

  // resolved data lines; undriven reads as zero
  assign dq = h_dq_oe ? h_dq_o : (d_dq_oe ? d_dq_o : '0);

  modport host (
    output bus_clk, sel_n, address_valid_n, oe_n, we_n, addr, h_dq_o, h_dq_oe,
    input  dq, wait_n
  );
  modport dev (
    input  bus_clk, sel_n, address_valid_n, oe_n, we_n, addr, dq,
    output d_dq_o, d_dq_oe, wait_n
  );
endinterface
`default_nettype wire

//--- verilog/psb_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module psb_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(D);

  logic [W-1:0] mem_q [D];
  logic [PW:0]  wp_q;
  logic [PW:0]  wp_d;
  logic [PW:0]  rp_q;
  logic [PW:0]  rp_d;
  logic         push;
  logic         pop;

  assign in_ready  = !((wp_q[PW] != rp_q[PW]) && (wp_q[PW-1:0] == rp_q[PW-1:0]));
  assign out_valid = (wp_q != rp_q);
  assign out_data  = mem_q[rp_q[PW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wp_d = wp_q + {{PW{1'b0}}, push};
    rp_d = rp_q + {{PW{1'b0}}, pop};
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
    if (push) begin
      mem_q[wp_q[PW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

//--- verilog/psb_dev.sv
`timescale 1ns/1ns
`default_nettype none
module psb_dev
  import psb_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // burst bus
  psb_bus_if.dev          bus,
  // configuration
  input  wire logic [2:0] latency_code,
  input  wire logic       fixed_latency,
  input  wire logic       sync_mode,
  input  wire logic       refresh_collision,
  // status
  output logic            busy
);
  psb_dev_state_t    state_q;
  psb_dev_state_t    state_d;
  logic [3:0]        cnt_q;
  logic [3:0]        cnt_d;
  logic [MEM_AW-1:0] addr_q;
  logic [MEM_AW-1:0] addr_d;
  logic [MEM_AW-1:0] wa;
  logic              wr_q;
  logic              wr_d;
  logic              clk_prev_q;
  logic              we_prev_q;
  logic              rise;
  logic              mem_we;
  logic [DW-1:0]     dq_q;
  logic [DW-1:0]     dq_d;
  logic [DW-1:0]     mem_q [MEM_DEPTH];

  assign rise        = bus.bus_clk & ~clk_prev_q;
  assign busy        = (state_q != DS_IDLE);
  assign bus.d_dq_o  = dq_q;
  assign bus.wait_n  = !(state_q == DS_LAT || state_q == DS_ROWEND);
  // data held on the lines while the clock is parked [R4]
  assign bus.d_dq_oe = !bus.sel_n && !bus.oe_n &&
                       ((!wr_q && (state_q == DS_DATA || state_q == DS_ROWEND)) ||
                        (state_q == DS_IDLE && !sync_mode));

  // ==========================================================
  // access sequencer
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    addr_d  = addr_q;
    wr_d    = wr_q;
    dq_d    = dq_q;
    wa      = addr_q;
    mem_we  = 1'b0;
    if (bus.sel_n) begin
      state_d = DS_IDLE;
    end else if (rise && !bus.address_valid_n) begin
      // a new address abandons any burst in progress [R9]
      state_d = DS_LAT;
      addr_d  = bus.addr[MEM_AW-1:0];
      wr_d    = ~bus.we_n;
      if (bus.we_n && !fixed_latency && refresh_collision) begin
        cnt_d = {latency_code, 1'b0}; // [R2]
      end else begin
        cnt_d = {1'b0, latency_code}; // [R1] [R6]
      end
    end else if (rise) begin
      case (state_q)
        DS_LAT: begin
          if (cnt_q <= 4'h1) begin
            state_d = DS_DATA;
            if (!wr_q) begin
              dq_d   = mem_q[addr_q];
              addr_d = addr_q + 1'b1;
            end
          end else begin
            cnt_d = cnt_q - 4'h1;
          end
        end
        DS_DATA: begin
          if (wr_q) begin
            mem_we = 1'b1;
            addr_d = addr_q + 1'b1;
            if (addr_d[ROW_AW-1:0] == '0) begin
              state_d = DS_ROWEND;
            end
          end else if (addr_q[ROW_AW-1:0] == '0) begin
            state_d = DS_ROWEND;
          end else begin
            dq_d   = mem_q[addr_q];
            addr_d = addr_q + 1'b1;
          end
        end
        default: begin
        end
      endcase
    end else if (state_q == DS_IDLE) begin
      // asynchronous access: read follows address, write on strobe release
      wa = bus.addr[MEM_AW-1:0];
      if (!sync_mode && !bus.oe_n) begin
        dq_d = mem_q[wa];
      end
      mem_we = ~we_prev_q & bus.we_n;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q    <= DS_IDLE;
      cnt_q      <= '0;
      addr_q     <= '0;
      wr_q       <= 1'b0;
      clk_prev_q <= 1'b0;
      we_prev_q  <= 1'b1;
      dq_q       <= '0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      addr_q     <= addr_d;
      wr_q       <= wr_d;
      clk_prev_q <= bus.bus_clk;
      we_prev_q  <= bus.we_n;
      dq_q       <= dq_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem_q[wa] <= bus.dq;
    end
  end
endmodule
`default_nettype wire

//--- verilog/psb_host.sv
// Contract
// R1 - latency is code plus one clocks
// R2 - refresh collision may double read latency
// R3 - suspended read keeps bus clock static
// R4 - suspended read keeps driving current word
// R5 - row-end wait: drop select within deadline
// R6 - write wait lasts exactly latency-code cycles
// R7 - give refresh chance every select-low interval
// R8 - back-to-back bursts stay under select-low limit
// R9 - new burst may interrupt after first word
// R10 - raise select between async and variable bursts
// R11 - select may stay low for fixed reads
// R12 - select high gap after async write
// R13 - select low at most four microseconds
// R14 - count select-low clocks, split long bursts
`timescale 1ns/1ns
`default_nettype none
module psb_host
  import psb_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // burst bus
  psb_bus_if.host          bus
);
  psb_host_state_t st_q;
  psb_host_state_t st_d;
  logic [2:0]      lc_q;
  logic [2:0]      lc_d;
  logic [AW-1:0]   areg_q;
  logic [AW-1:0]   areg_d;
  logic [7:0]      creg_q;
  logic [7:0]      creg_d;
  logic            err_q;
  logic            err_d;
  logic [31:0]     prdata_q;
  logic [31:0]     prdata_d;
  logic            wr_q;
  logic            wr_d;
  logic            async_q;
  logic            async_d;
  logic [AW-1:0]   baddr_q;
  logic [AW-1:0]   baddr_d;
  logic [7:0]      left_q;
  logic [7:0]      left_d;
  logic [7:0]      seg_q;
  logic [7:0]      seg_d;
  logic [7:0]      to_row;
  logic [4:0]      edge_q;
  logic [4:0]      edge_d;
  logic [5:0]      low_q;
  logic [5:0]      low_d;
  logic [3:0]      cnt_q;
  logic [3:0]      cnt_d;
  logic            clk_q;
  logic            clk_d;
  logic            sel_n_q;
  logic            sel_n_d;
  logic            adv_n_q;
  logic            adv_n_d;
  logic            oe_n_q;
  logic            oe_n_d;
  logic            we_n_q;
  logic            we_n_d;
  logic [DW-1:0]   dq_q;
  logic [DW-1:0]   dq_d;
  logic            dq_oe_q;
  logic            dq_oe_d;
  logic            armed_q;
  logic            armed_d;
  logic            got_q;
  logic            got_d;
  logic            fault_q;
  logic            fault_d;
  logic [DW-1:0]   rd_q;
  logic [DW-1:0]   rd_d;
  logic            rd_valid_q;
  logic            rd_valid_d;
  logic            acc;
  logic            done;
  logic            push;
  logic            pop;
  logic            f_in_ready;
  logic            f_out_valid;
  logic [DW-1:0]   f_out_data;

  // ==========================================================
  // apb handshake
  assign acc     = psel && penable;
  assign push    = acc && pwrite && (paddr == REG_WDATA) && f_in_ready;
  assign pready  = !(acc && pwrite && (paddr == REG_WDATA) && !f_in_ready);
  assign done    = acc && pready;
  assign pslverr = acc && !(paddr == REG_CTRL || paddr == REG_CFG || paddr == REG_ADDR ||
                            paddr == REG_COUNT || paddr == REG_WDATA ||
                            paddr == REG_RDATA || paddr == REG_STATUS);
  assign prdata  = prdata_q;

  // ==========================================================
  // bus pins
  assign bus.bus_clk         = clk_q;
  assign bus.sel_n           = sel_n_q;
  assign bus.address_valid_n = adv_n_q;
  assign bus.oe_n            = oe_n_q;
  assign bus.we_n            = we_n_q;
  assign bus.addr            = baddr_q;
  assign bus.h_dq_o          = dq_q;
  assign bus.h_dq_oe         = dq_oe_q;

  assign to_row = 8'(ROW_WORDS) - {1'b0, baddr_q[ROW_AW-1:0]};

  psb_fifo #(.W(DW), .D(FIFO_DEPTH)) u_wfifo (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_valid  (push),
    .in_ready  (f_in_ready),
    .in_data   (pwdata[DW-1:0]),
    .out_valid (f_out_valid),
    .out_ready (pop),
    .out_data  (f_out_data)
  );

  // ==========================================================
  // registers and sequencer
  always_comb begin
    st_d = st_q;       lc_d = lc_q;       areg_d = areg_q;   creg_d = creg_q;
    err_d = err_q;     wr_d = wr_q;       async_d = async_q; baddr_d = baddr_q;
    left_d = left_q;   seg_d = seg_q;     edge_d = edge_q;   low_d = low_q;
    cnt_d = cnt_q;     clk_d = clk_q;     sel_n_d = sel_n_q; adv_n_d = adv_n_q;
    oe_n_d = oe_n_q;   we_n_d = we_n_q;   dq_d = dq_q;       dq_oe_d = dq_oe_q;
    armed_d = armed_q; got_d = got_q;     fault_d = fault_q; rd_d = rd_q;
    rd_valid_d = rd_valid_q;
    prdata_d = prdata_q;
    pop = 1'b0;

    if (psel && !penable) begin
      prdata_d = '0;
      if (paddr == REG_CTRL) begin
        prdata_d[CTRL_WRITE] = wr_q;
        prdata_d[CTRL_ASYNC] = async_q;
      end else if (paddr == REG_CFG) begin
        prdata_d[2:0] = lc_q;
      end else if (paddr == REG_ADDR) begin
        prdata_d[AW-1:0] = areg_q;
      end else if (paddr == REG_COUNT) begin
        prdata_d[7:0] = creg_q;
      end else if (paddr == REG_RDATA) begin
        prdata_d[DW-1:0] = rd_q;
      end else if (paddr == REG_STATUS) begin
        prdata_d[STAT_BUSY]     = (st_q != HS_IDLE);
        prdata_d[STAT_RD_VALID] = rd_valid_q;
        prdata_d[STAT_FULL]     = !f_in_ready;
        prdata_d[STAT_EMPTY]    = !f_out_valid;
        prdata_d[STAT_WAIT_ERR] = err_q;
      end
    end
    if (done && pwrite) begin
      if (paddr == REG_CFG) begin
        lc_d = pwdata[2:0];
      end else if (paddr == REG_ADDR) begin
        areg_d = pwdata[AW-1:0];
      end else if (paddr == REG_COUNT) begin
        creg_d = pwdata[7:0];
      end else if (paddr == REG_STATUS && pwdata[STAT_WAIT_ERR]) begin
        err_d = 1'b0;
      end
    end
    if (done && !pwrite && paddr == REG_RDATA) begin
      rd_valid_d = 1'b0;
    end

    case (st_q)
      HS_IDLE: begin
        if (done && pwrite && paddr == REG_CTRL && pwdata[CTRL_GO] && creg_q != '0) begin
          wr_d    = pwdata[CTRL_WRITE];
          async_d = pwdata[CTRL_ASYNC];
          baddr_d = areg_q;
          left_d  = creg_q;
          st_d    = pwdata[CTRL_ASYNC] ? HS_ASETUP : HS_START;
        end
      end
      HS_START: begin
        // each burst stops at the row end and restarts after a gap [R5]
        seg_d   = (left_q < to_row) ? left_q : to_row;
        sel_n_d = 1'b0;
        adv_n_d = 1'b0;
        we_n_d  = ~wr_q;
        oe_n_d  = wr_q;
        edge_d  = '0;
        low_d   = '0;
        st_d    = HS_RUN;
      end
      HS_RUN: begin
        low_d = low_q + 6'h01; // [R14]
        if (clk_q) begin
          clk_d   = 1'b0;
          adv_n_d = 1'b1;
        end else if (seg_q == '0 || fault_q || low_q >= SELECT_LOW_LIMIT) begin
          // end of segment, wait fault or select-low budget spent [R8] [R13] [R14] [R5]
          sel_n_d = 1'b1;
          oe_n_d  = 1'b1;
          we_n_d  = 1'b1;
          dq_oe_d = 1'b0;
          armed_d = 1'b0;
          got_d   = 1'b0;
          fault_d = 1'b0;
          cnt_d   = GAP_CYC;
          st_d    = HS_GAP;
        end else if (wr_q && edge_q > {2'b00, lc_q} && !armed_q) begin
          // write data due; clock parked low until the fifo has a word
          if (f_out_valid) begin
            dq_d    = f_out_data;
            dq_oe_d = 1'b1;
            armed_d = 1'b1;
          end
        end else if (!(!wr_q && rd_valid_q)) begin
          // a full read buffer parks the clock low with no rising edge [R3]
          clk_d  = 1'b1;
          edge_d = (edge_q == 5'h1F) ? edge_q : edge_q + 5'h01;
          if (wr_q && armed_q) begin
            // word taken after the fixed write latency [R6]
            pop     = 1'b1;
            armed_d = 1'b0;
            seg_d   = seg_q - 8'h01;
            left_d  = left_q - 8'h01;
            baddr_d = baddr_q + 1'b1;
          end else if (!wr_q && edge_q >= 5'h02) begin
            if (bus.wait_n) begin
              // wait released marks valid data, however long it was held [R1] [R2]
              rd_d       = bus.dq;
              rd_valid_d = 1'b1;
              got_d      = 1'b1;
              seg_d      = seg_q - 8'h01;
              left_d     = left_q - 8'h01;
              baddr_d    = baddr_q + 1'b1;
            end else if (got_q) begin
              fault_d = 1'b1; // [R5]
              err_d   = 1'b1;
            end
          end
        end
      end
      HS_ASETUP: begin
        if (wr_q ? f_out_valid : !rd_valid_q) begin
          sel_n_d = 1'b0;
          adv_n_d = 1'b0;
          we_n_d  = ~wr_q;
          oe_n_d  = wr_q;
          dq_d    = f_out_data;
          dq_oe_d = wr_q;
          cnt_d   = ASYNC_CYC;
          st_d    = HS_ASYNC;
        end
      end
      HS_ASYNC: begin
        if (cnt_q > 4'h1) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          if (wr_q) begin
            we_n_d = 1'b1;
            pop    = 1'b1;
          end else begin
            rd_d       = bus.dq;
            rd_valid_d = 1'b1;
          end
          left_d = '0;
          st_d   = HS_AEND;
        end
      end
      HS_AEND: begin
        sel_n_d = 1'b1;
        adv_n_d = 1'b1;
        oe_n_d  = 1'b1;
        dq_oe_d = 1'b0;
        cnt_d   = GAP_CYC;
        st_d    = HS_GAP;
      end
      default: begin
        // select held high between every pair of operations [R7] [R10] [R11] [R12]
        if (cnt_q <= 4'h1) begin
          st_d = (left_q == '0) ? HS_IDLE : HS_START;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= HS_IDLE;      lc_q <= LATENCY_CODE_RST; areg_q <= '0;    creg_q <= '0;
      err_q <= 1'b0;        wr_q <= 1'b0;       async_q <= 1'b0;       baddr_q <= '0;
      left_q <= '0;         seg_q <= '0;        edge_q <= '0;          low_q <= '0;
      cnt_q <= '0;          clk_q <= 1'b0;      sel_n_q <= 1'b1;       adv_n_q <= 1'b1;
      oe_n_q <= 1'b1;       we_n_q <= 1'b1;     dq_q <= '0;            dq_oe_q <= 1'b0;
      armed_q <= 1'b0;      got_q <= 1'b0;      fault_q <= 1'b0;       rd_q <= '0;
      rd_valid_q <= 1'b0;   prdata_q <= '0;
    end else begin
      st_q <= st_d;         lc_q <= lc_d;       areg_q <= areg_d;      creg_q <= creg_d;
      err_q <= err_d;       wr_q <= wr_d;       async_q <= async_d;    baddr_q <= baddr_d;
      left_q <= left_d;     seg_q <= seg_d;     edge_q <= edge_d;      low_q <= low_d;
      cnt_q <= cnt_d;       clk_q <= clk_d;     sel_n_q <= sel_n_d;    adv_n_q <= adv_n_d;
      oe_n_q <= oe_n_d;     we_n_q <= we_n_d;   dq_q <= dq_d;          dq_oe_q <= dq_oe_d;
      armed_q <= armed_d;   got_q <= got_d;     fault_q <= fault_d;    rd_q <= rd_d;
      rd_valid_q <= rd_valid_d;
      prdata_q <= prdata_d;
    end
  end
endmodule
`default_nettype wire

//--- bench/psb_bus_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module psb_bus_asserts
  import psb_pkg::*;
(
  // clock and reset
  input wire logic          core_clk,
  input wire logic          reset,
  // burst bus
  input wire logic          bus_clk,
  input wire logic          sel_n,
  input wire logic          address_valid_n,
  input wire logic          oe_n,
  input wire logic          h_dq_oe,
  input wire logic [DW-1:0] d_dq_o,
  input wire logic          d_dq_oe,
  input wire logic          wait_n,
  // device configuration
  input wire logic [2:0]    latency_code,
  input wire logic          fixed_latency,
  input wire logic          refresh_collision
);
  logic [5:0] low_q;
  logic [5:0] low_d;
  logic [5:0] sel_q;
  logic [5:0] sel_d;

  // ==========================================================
  // run lengths of wait low and select low
  always_comb begin
    low_d = (reset || wait_n) ? 6'h00 : low_q + 6'h01;
    sel_d = (reset || sel_n) ? 6'h00 : sel_q + 6'h01;
  end

  always_ff @(posedge core_clk) begin
    low_q <= low_d;
    sel_q <= sel_d;
  end

  // ==========================================================
  // properties
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  a_sel_low_limit: assert property (!sel_n |-> sel_q < 6'(MAX_SELECT_LOW_CYC))
    else $error("select held low too long");
  a_refresh_gap: assert property ($rose(sel_n) |-> sel_n [*2])
    else $error("select high gap too short");
  a_addr_to_wait: assert property (!sel_n && !address_valid_n && $rose(bus_clk) |=> !wait_n)
    else $error("wait not asserted after address");
  a_read_latency: assert property ($rose(wait_n) && !sel_n && !oe_n &&
    (fixed_latency || !refresh_collision) |-> low_q == 6'(2 * latency_code))
    else $error("read latency wrong");
  a_collide_latency: assert property ($rose(wait_n) && !sel_n && !oe_n &&
    !fixed_latency && refresh_collision |-> low_q == 6'(4 * latency_code))
    else $error("collision latency wrong");
  a_write_wait: assert property ($rose(wait_n) && !sel_n && oe_n |->
    low_q == 6'(2 * latency_code))
    else $error("write wait length wrong");
  a_suspend_hold: assert property (address_valid_n && d_dq_oe && $past(d_dq_oe) &&
    !oe_n && !bus_clk && !$past(bus_clk) |-> $stable(d_dq_o))
    else $error("suspended word changed");
  a_clk_needs_sel: assert property ($rose(bus_clk) |-> !sel_n)
    else $error("bus clock rose while deselected");
  a_no_contention: assert property (!(h_dq_oe && d_dq_oe))
    else $error("both ends drive data");
  a_deselect_idle: assert property (sel_n |=> wait_n && !(d_dq_oe && address_valid_n))
    else $error("device busy after deselect");
endmodule
`default_nettype wire

//--- bench/psram_burst_bus_sequencing_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module psram_burst_bus_sequencing_tb_top
  import psb_pkg::*;
;
  typedef struct {logic [2:0] lc; logic fix; logic col; int n;} psb_row_t;
  psb_row_t    rows [5] = '{'{3'h2, 1'b1, 1'b0, 2}, '{3'h4, 1'b1, 1'b0, 1},
                            '{3'h2, 1'b0, 1'b0, 4}, '{3'h2, 1'b0, 1'b1, 4},
                            '{3'h3, 1'b1, 1'b0, 24}};
  logic        core_clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [2:0]  lc;
  logic        fixed;
  logic        sync;
  logic        coll;
  logic        busy;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          low_run = 0;
  int          low_max = 0;
  int          hi_run = 0;
  int          hi_min = 99;

  psb_bus_if bus ();
  psb_host u_psb_host (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(bus));
  psb_dev u_psb_dev (.core_clk(core_clk), .reset(reset), .bus(bus), .latency_code(lc),
    .fixed_latency(fixed), .sync_mode(sync), .refresh_collision(coll), .busy(busy));
  psb_bus_asserts u_psb_bus_asserts (.core_clk(core_clk), .reset(reset),
    .bus_clk(bus.bus_clk), .sel_n(bus.sel_n), .address_valid_n(bus.address_valid_n),
    .oe_n(bus.oe_n), .h_dq_oe(bus.h_dq_oe), .d_dq_o(bus.d_dq_o), .d_dq_oe(bus.d_dq_oe),
    .wait_n(bus.wait_n), .latency_code(lc), .fixed_latency(fixed),
    .refresh_collision(coll));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ==========================================================
  // select low and high run lengths seen on the wire
  always @(posedge core_clk) begin
    if (!reset && !bus.sel_n && hi_run > 0 && hi_run < hi_min) hi_min = hi_run;
    hi_run = bus.sel_n ? hi_run + 1 : 0;
    low_run = bus.sel_n ? 0 : low_run + 1;
    if (low_run > low_max) low_max = low_run;
  end

  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] pat(input int b, input int i);
    return {16'h0000, 8'(b), 8'(i) ^ 8'h5A};
  endfunction

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // one transfer; writes fill the buffer first, then stall on it while it drains
  task automatic run(input logic wr, input logic asy, input int n, input int b);
    int m;
    m = (n > FIFO_DEPTH) ? FIFO_DEPTH : n;
    apb(1'b1, REG_ADDR, 32'(b));
    apb(1'b1, REG_COUNT, 32'(n));
    if (wr) for (int i = 0; i < m; i++) apb(1'b1, REG_WDATA, pat(b, i));
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk("fifo_full", 32'(rd[STAT_FULL]), 32'(wr && m == FIFO_DEPTH));
    apb(1'b1, REG_CTRL, {29'h0000_0000, asy, wr, 1'b1});
    if (wr) for (int i = m; i < n; i++) apb(1'b1, REG_WDATA, pat(b, i));
    if (!wr) for (int i = 0; i < n; i++) begin
      do apb(1'b0, REG_STATUS, 32'h0000_0000); while (rd[STAT_RD_VALID] !== 1'b1);
      apb(1'b0, REG_RDATA, 32'h0000_0000);
      chk("rdata", rd, pat(b, i));
    end
    do apb(1'b0, REG_STATUS, 32'h0000_0000); while (rd[STAT_BUSY] === 1'b1);
    chk("dev_busy", 32'(busy), 32'h0000_0000);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    lc = LATENCY_CODE_RST;
    fixed = 1'b1;
    sync = 1'b1;
    coll = 1'b0;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk("status_rst", rd, 32'h0000_0008);
    apb(1'b0, REG_CFG, 32'h0000_0000);
    chk("cfg_rst", rd, 32'h0000_0002);
    chk("sel_idle", 32'(bus.sel_n), 32'h0000_0001);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk("slverr", 32'(err), 32'h0000_0001);
    foreach (rows[k]) begin
      lc <= rows[k].lc;
      fixed <= rows[k].fix;
      coll <= rows[k].col;
      apb(1'b1, REG_CFG, 32'(rows[k].lc));
      run(1'b1, 1'b0, rows[k].n, 16 * k);
      run(1'b0, 1'b0, rows[k].n, 16 * k);
    end
    // bursts that straddle a row end are split by the host
    run(1'b1, 1'b0, 8, 124);
    run(1'b0, 1'b0, 8, 124);
    sync <= 1'b0;
    run(1'b1, 1'b1, 1, 8'hC0);
    run(1'b0, 1'b1, 1, 8'hC0);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk("wait_err", 32'(rd[STAT_WAIT_ERR]), 32'h0000_0000);
    chk("sel_low_max", 32'(low_max <= MAX_SELECT_LOW_CYC), 32'h0000_0001);
    chk("sel_high_min", 32'(hi_min >= 2), 32'h0000_0001);
    // reset after the last transfer has finished restores the configuration
    apb(1'b1, REG_CFG, 32'h0000_0005);
    reset <= 1'b1;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    apb(1'b0, REG_CFG, 32'h0000_0000);
    chk("cfg_rerst", rd, 32'(LATENCY_CODE_RST));
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk("status_rerst", rd, 32'h0000_0008);
    chk("sel_rerst", 32'(bus.sel_n), 32'h0000_0001);
    close_out();
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
